// ---- verilog/hap_pipes.sv ----
// delivery pipes, command mailbox and transaction timer of the adapter
//
// The implementer's own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`include "hap_cfg.svh"
module hap_pipes
    import hap_pkg::*;
#(
    parameter logic [31:0] TMO_CYCLES = 32'(`HAP_TMO_CYCLES)
) (
    input wire logic clock, // 10 MHz system clock
    input wire logic reset, // synchronous, active high
    input wire logic [11:0] avs_address, // byte address
    input wire logic avs_read, // bus read request
    input wire logic avs_write, // bus write request
    input wire logic [31:0] avs_writedata, // bus write data
    input wire logic [3:0] avs_byteenable, // write byte lanes
    output logic [31:0] avs_readdata, // bus read data
    output logic avs_waitrequest, // high until request taken
    input wire logic init_start, // start pipe initialisation
    output logic init_busy, // initialisation running
    input wire logic enq_valid, // enqueue request, held to done
    input wire hap_enq_t enq_data, // element to enqueue
    output logic enq_done, // enqueue finished, one cycle
    output logic enq_refused, // with done: no request credit or halted
    output logic result_wr, // result word store, one cycle
    output hap_result_t result_data, // result word to store
    input wire logic deq_req, // dequeue request, held to done
    output logic deq_done, // dequeue finished, one cycle
    output logic deq_empty, // with done: pipe was empty or halted
    output hap_elem_t deq_elem, // element taken
    input wire logic timer_exempt, // oldest is a resource_ready_test
    output logic adapter_irq, // host pipe or command write pulse
    output hap_cmd_t cmd_out, // latched command and parameter
    input wire logic cmd_taken, // adapter has read the command
    input wire logic cmd_complete, // adapter finished the command
    input wire logic [2:0] cmd_status, // completion code
    input wire logic err_valid, // load error register
    input wire logic [31:0] err_code, // error code to load
    output logic host_irq, // host interrupt level
    output logic [7:0] request_credit, // adapter request credit
    output logic halted // timed out, waiting for reset
);
    // ==================================================================
    // helpers
    // ==================================================================
    function automatic logic [31:0] be_merge(input logic [31:0] old_w,
            input logic [31:0] new_w, input logic [3:0] be);
        logic [31:0] r;
        r = old_w;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = new_w[8*i +: 8];
            end
        end
        return r;
    endfunction : be_merge

    // ==================================================================
    // state
    // ==================================================================
    // low half host outgoing pipe, high half adapter outgoing pipe
    logic [31:0] mem [0:2*`HAP_QLEN-1];
    hap_state_t state_ff, nxt_state;
    logic wait_ff, rdok_ff;
    logic [31:0] rdata_ff;
    logic [7:0] enq_ptr_ff, deq_ptr_ff, init_idx_ff;
    logic enq_ph_ff, deq_ph_ff;
    logic [7:0] credit_ff, out_cnt_ff;
    logic [31:0] tmr_ff;
    logic halt_ff;
    logic [7:0] cmd_ff;
    logic [31:0] param_ff, err_ff;
    logic [2:0] code_ff;
    logic busy_ff, hirq_ff, cor_ff, dl_lock_ff;
    logic airq_ff, enq_done_ff, enq_ref_ff, res_wr_ff;
    hap_result_t res_ff;
    logic deq_done_ff, deq_empty_ff;
    hap_elem_t deq_elem_ff;

    // ==================================================================
    // bus decode
    // ==================================================================
    // engine work wins over the bus; a grant lasts exactly one cycle
    wire logic bus_req = avs_read | avs_write;
    wire logic eng_want = init_start | enq_valid | deq_req;
    wire logic go_bus = bus_req & wait_ff & (state_ff == HAP_IDLE)
        & ~eng_want;
    wire logic grant = ~wait_ff;
    wire logic in_mem = ~avs_address[11];
    wire logic [8:0] bus_idx = avs_address[10:2];
    wire logic in_hpipe = in_mem & ~avs_address[10];
    wire logic a_cmd = avs_address == `HAP_ADDR_CMD;
    wire logic a_param = avs_address == `HAP_ADDR_PARAM;
    wire logic a_stat = avs_address == `HAP_ADDR_STATUS;
    wire logic a_ctl = avs_address == `HAP_ADDR_CONTROL;
    wire logic a_err = avs_address == `HAP_ADDR_ERROR;
    wire logic bus_wr = grant & avs_write;
    wire logic bus_rd = grant & avs_read;
    wire logic mem_bus_wr = bus_wr & in_mem;

    // status word seen by the host
    wire logic [31:0] stat_word = {21'h0, code_ff, 6'h0, hirq_ff, busy_ff};
    // unmapped addresses read as zero and ignore writes
    wire logic [31:0] rd_word = in_mem ? mem[bus_idx]
        : a_cmd ? {24'h0, cmd_ff}
        : a_param ? param_ff
        : a_stat ? stat_word
        : a_ctl ? {31'h0, cor_ff}
        : a_err ? err_ff
        : 32'h0;

    // ==================================================================
    // engine decode
    // ==================================================================
    wire logic eng_idle = (state_ff == HAP_IDLE) & wait_ff
        & ~enq_done_ff & ~deq_done_ff;
    wire logic do_init = eng_idle & init_start;
    wire logic do_enq = eng_idle & ~init_start & enq_valid;
    wire logic do_deq = eng_idle & ~init_start & ~enq_valid & deq_req;
    wire logic no_credit = ~enq_data.reply & (credit_ff == 8'h0);
    // requests and failing replies need a result store first
    wire logic need_res = ~enq_data.reply
        | (enq_data.result != `HAP_RESULT_OK);
    wire logic elem_wr = (state_ff == HAP_ELEM);
    wire logic init_wr = (state_ff == HAP_INIT);
    wire logic init_last = init_idx_ff == 8'(`HAP_QLEN - 1);
    // element built with phase in bit 0 and reply flag in bit 1
    wire hap_elem_t enq_elem = '{tcb: enq_data.tcb,
        no_status: enq_data.no_status, zero: 1'b0,
        reply: enq_data.reply, phase: enq_ph_ff};
    // dequeue reads the host outgoing pipe at its pointer
    wire hap_elem_t head = mem[{1'b0, deq_ptr_ff}];
    wire logic head_ok = (head.phase == deq_ph_ff) & ~halt_ff;
    wire logic deq_take = do_deq & head_ok;
    wire logic enq_fin = elem_wr;
    wire logic tmo_hit = ~halt_ff & (out_cnt_ff != 8'h0)
        & (tmr_ff == TMO_CYCLES - 32'h1);
    wire logic cmd_wr = bus_wr & a_cmd & ~halt_ff & ~dl_lock_ff;
    wire logic host_pipe_evt = bus_wr & in_hpipe & ~halt_ff;

    // ==================================================================
    // engine state machine
    // ==================================================================
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            HAP_IDLE: begin
                if (do_init) begin
                    nxt_state = HAP_INIT;
                end else if (do_enq & ~no_credit & ~halt_ff) begin
                    nxt_state = need_res ? HAP_RES : HAP_ELEM;
                end
            end
            HAP_INIT: begin
                if (init_last) begin
                    nxt_state = HAP_IDLE;
                end
            end
            HAP_RES: nxt_state = HAP_ELEM;
            HAP_ELEM: nxt_state = HAP_IDLE;
            default: nxt_state = HAP_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_ff <= HAP_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ==================================================================
    // pipe memory
    // ==================================================================
    // one write port: bus, init fill or enqueue, never two at once
    always_ff @(posedge clock) begin
        if (init_wr) begin
            mem[{1'b0, init_idx_ff}] <= `HAP_DUMMY_ELEM;
        end else if (elem_wr) begin
            mem[{1'b1, enq_ptr_ff}] <= enq_elem;
        end else if (mem_bus_wr) begin
            mem[bus_idx] <= be_merge(mem[bus_idx], avs_writedata,
                avs_byteenable);
        end
    end

    // ==================================================================
    // bus slave
    // ==================================================================
    // read data captured when granting, so it stands in the grant cycle
    always_ff @(posedge clock) begin
        if (reset) begin
            wait_ff <= 1'b1;
            rdata_ff <= 32'h0;
        end else begin
            wait_ff <= ~go_bus;
            rdata_ff <= go_bus ? rd_word : rdata_ff;
        end
    end

    // ==================================================================
    // pointers, phases and credit
    // ==================================================================
    // 8-bit pointers wrap with the 256-element pipes
    always_ff @(posedge clock) begin
        if (reset | do_init) begin
            enq_ptr_ff <= 8'h0;
            deq_ptr_ff <= 8'h0;
            enq_ph_ff <= 1'b0;
            deq_ph_ff <= 1'b0;
            credit_ff <= 8'(`HAP_CREDIT_MAX);
        end else begin
            if (enq_fin) begin
                enq_ptr_ff <= enq_ptr_ff + 8'h1;
                enq_ph_ff <= enq_ph_ff ^ (enq_ptr_ff == 8'hff);
            end
            if (deq_take) begin
                deq_ptr_ff <= deq_ptr_ff + 8'h1;
                deq_ph_ff <= deq_ph_ff ^ (deq_ptr_ff == 8'hff);
            end
            credit_ff <= credit_ff
                - {7'h0, enq_fin & ~enq_data.reply}
                + {7'h0, deq_take & head.reply};
        end
    end

    always_ff @(posedge clock) begin
        if (reset | ~init_wr) begin
            init_idx_ff <= 8'h0;
        end else begin
            init_idx_ff <= init_idx_ff + 8'h1;
        end
    end

    // ==================================================================
    // adapter side answers
    // ==================================================================
    // refusal answers at once; the result store pulse comes in the same cycle as the element write
    always_ff @(posedge clock) begin
        if (reset) begin
            enq_done_ff <= 1'b0;
            enq_ref_ff <= 1'b0;
            res_wr_ff <= 1'b0;
            res_ff <= '0;
        end else begin
            enq_done_ff <= enq_fin | (do_enq & (no_credit | halt_ff));
            enq_ref_ff <= do_enq & (no_credit | halt_ff);
            res_wr_ff <= state_ff == HAP_RES;
            // requests preset success; failing replies carry the error
            res_ff <= enq_data.reply ? enq_data.result
                : `HAP_RESULT_OK;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            deq_done_ff <= 1'b0;
            deq_empty_ff <= 1'b0;
            deq_elem_ff <= '0;
        end else begin
            deq_done_ff <= do_deq;
            deq_empty_ff <= do_deq & ~head_ok;
            deq_elem_ff <= deq_take ? head : deq_elem_ff;
        end
    end

    // ==================================================================
    // transaction timer
    // ==================================================================
    // one timer restarted on every reply: a limitation, it times the
    // gap between replies while any host request is outstanding
    always_ff @(posedge clock) begin
        if (reset) begin
            out_cnt_ff <= 8'h0;
            tmr_ff <= 32'h0;
            halt_ff <= 1'b0;
        end else begin
            out_cnt_ff <= out_cnt_ff + {7'h0, deq_take & ~head.reply}
                - {7'h0, enq_fin & enq_data.reply & (out_cnt_ff != 8'h0)};
            if ((out_cnt_ff == 8'h0) | (enq_fin & enq_data.reply)) begin
                tmr_ff <= 32'h0;
            end else if (~timer_exempt & ~halt_ff) begin
                tmr_ff <= tmr_ff + 32'h1;
            end
            halt_ff <= halt_ff | tmo_hit;
        end
    end

    // ==================================================================
    // command mailbox
    // ==================================================================
    always_ff @(posedge clock) begin
        if (reset) begin
            cmd_ff <= 8'h0;
            param_ff <= 32'h0;
            cor_ff <= `HAP_CTL_RESET;
            dl_lock_ff <= 1'b0;
        end else begin
            if (cmd_wr) begin
                cmd_ff <= avs_writedata[7:0];
            end
            if (bus_wr & a_param) begin
                param_ff <= be_merge(param_ff, avs_writedata,
                    avs_byteenable);
            end
            if (bus_wr & a_ctl) begin
                cor_ff <= avs_writedata[`HAP_CTL_COR];
            end
            // download locks the command register until the next reset; the parameter stays writable
            dl_lock_ff <= dl_lock_ff
                | (cmd_wr & (avs_writedata[7:0] == `HAP_CMD_DOWNLOAD));
        end
    end

    // set wins over clear on busy and on the host interrupt
    always_ff @(posedge clock) begin
        if (reset) begin
            busy_ff <= 1'b0;
            hirq_ff <= 1'b0;
            code_ff <= 3'h0;
            err_ff <= 32'h0;
        end else begin
            busy_ff <= cmd_wr | (busy_ff & ~cmd_taken);
            hirq_ff <= cmd_complete | enq_fin | tmo_hit
                | (hirq_ff & ~(bus_rd & a_stat & cor_ff));
            if (cmd_complete) begin
                code_ff <= cmd_status;
            end
            if (tmo_hit) begin
                err_ff <= `HAP_ERR_TIMEOUT;
            end else if (err_valid) begin
                err_ff <= err_code;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            airq_ff <= 1'b0;
        end else begin
            airq_ff <= cmd_wr | host_pipe_evt;
        end
    end

    // ==================================================================
    // outputs
    // ==================================================================
    assign avs_readdata = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign init_busy = init_wr;
    assign enq_done = enq_done_ff;
    assign enq_refused = enq_ref_ff;
    assign result_wr = res_wr_ff;
    assign result_data = res_ff;
    assign deq_done = deq_done_ff;
    assign deq_empty = deq_empty_ff;
    assign deq_elem = deq_elem_ff;
    assign adapter_irq = airq_ff;
    assign cmd_out = '{code: cmd_ff, param: param_ff};
    assign host_irq = hirq_ff;
    assign request_credit = credit_ff;
    assign halted = halt_ff;
endmodule : hap_pipes

// ---- verilog/hap_cfg.svh ----
// constants for the host adapter delivery pipes block
`ifndef HAP_CFG_SVH
`define HAP_CFG_SVH
// pipe geometry and request credit
`define HAP_QLEN 256
`define HAP_HOST_MAX 200
`define HAP_CREDIT_MAX (`HAP_QLEN - 1 - `HAP_HOST_MAX)
// byte addresses on the register bus
`define HAP_ADDR_HPIPE 12'h000
`define HAP_ADDR_APIPE 12'h400
`define HAP_ADDR_CMD 12'h800
`define HAP_ADDR_PARAM 12'h804
`define HAP_ADDR_STATUS 12'h808
`define HAP_ADDR_CONTROL 12'h80c
`define HAP_ADDR_ERROR 12'h810
// status and control fields
`define HAP_ST_BUSY 0
`define HAP_ST_IRQ 1
`define HAP_ST_CODE_LSB 8
`define HAP_CTL_COR 0
`define HAP_CTL_RESET 1'h0
// command codes and fixed words
`define HAP_CMD_DOWNLOAD 8'h31
`define HAP_DUMMY_ELEM 32'h0000_0001
`define HAP_RESULT_OK 32'h0000_0000
`define HAP_ERR_TIMEOUT 32'h0000_0001
// transaction timeout
`define HAP_TMO_S 120
`define HAP_CLK_HZ 10000000
`define HAP_TMO_CYCLES (64'(`HAP_TMO_S) * 64'(`HAP_CLK_HZ))
`endif

// ---- verilog/hap_pkg.sv ----
// types shared by the host adapter delivery pipes block
package hap_pkg;
    // pipe element: 16-byte aligned pointer plus four flag bits
    typedef struct packed {
        logic [27:0] tcb;
        logic no_status;
        logic zero;
        logic reply;
        logic phase;
    } hap_elem_t;
    // result word of a transaction
    typedef struct packed {
        logic [7:0] rsvd;
        logic [7:0] net;
        logic [15:0] app;
    } hap_result_t;
    // one scatter/gather entry: fragment address then byte length
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] len;
    } hap_sg_t;
    // enqueue request from the adapter processor
    typedef struct packed {
        logic [27:0] tcb;
        logic reply;
        logic no_status;
        hap_result_t result;
    } hap_enq_t;
    // command handed to the adapter processor
    typedef struct packed {
        logic [7:0] code;
        logic [31:0] param;
    } hap_cmd_t;
    typedef enum logic [1:0] {
        HAP_IDLE,
        HAP_INIT,
        HAP_RES,
        HAP_ELEM
    } hap_state_t;
endpackage : hap_pkg

// ---- dv/hap_pipes_monitor.sv ----
// assertion checker for the delivery pipes block
`timescale 1ns/1ps
module hap_pipes_monitor (
    input wire logic clock, // system clock
    input wire logic reset, // sync reset
    input wire logic avs_read, // bus read
    input wire logic avs_write, // bus write
    input wire logic avs_waitrequest, // bus stall
    input wire logic init_busy, // init running
    input wire logic enq_done, // enqueue done
    input wire logic enq_refused, // enqueue refused
    input wire logic result_wr, // result store
    input wire logic deq_done, // dequeue done
    input wire logic host_irq, // host interrupt
    input wire logic [7:0] request_credit, // credit
    input wire logic halted // timed out
);
    // ====
    // length of the current init run, too long for a repetition
    logic [8:0] busy_cnt_ff;
    always_ff @(posedge clock) begin
        busy_cnt_ff <= (reset | ~init_busy) ? 9'h000 : busy_cnt_ff + 9'h001;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // ====
    // properties
    a_credit_cap: assert property (request_credit <= 8'h37)
        else $error("request credit above maximum");
    a_init_len: assert property ($fell(init_busy)
        |-> busy_cnt_ff == 9'h100) else $error("init run not 256 cycles");
    a_grant_pulse: assert property (!avs_waitrequest
        |=> avs_waitrequest) else $error("grant longer than one cycle");
    a_grant_cause: assert property (!avs_waitrequest
        |-> $past(avs_read || avs_write)) else $error("grant without request");
    a_refuse_done: assert property (enq_refused |-> enq_done)
        else $error("refusal outside done");
    a_refuse_credit: assert property (enq_refused && !halted
        |-> request_credit == 8'h00) else $error("refused with credit left");
    a_result_first: assert property (result_wr
        |=> enq_done && !enq_refused) else $error("no done after result");
    a_deq_pulse: assert property (deq_done |=> !deq_done)
        else $error("dequeue done not a pulse");
    a_halt_hold: assert property (halted |=> halted)
        else $error("halt dropped before reset");
    a_halt_irq: assert property ($rose(halted) |-> host_irq)
        else $error("halt without host interrupt");
endmodule : hap_pipes_monitor
bind hap_pipes hap_pipes_monitor u_mon (.clock(clock), .reset(reset),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .init_busy(init_busy),
    .enq_done(enq_done), .enq_refused(enq_refused), .result_wr(result_wr),
    .deq_done(deq_done), .host_irq(host_irq),
    .request_credit(request_credit), .halted(halted));

// ---- dv/hap_host_model.sv ----
// host driver model: bus master for the adapter window
`timescale 1ns/1ps
`include "hap_cfg.svh"
module hap_host_model (
    input wire logic clock, // system clock
    output logic [11:0] avs_address, // byte address
    output logic avs_read, // read request
    output logic avs_write, // write request
    output logic [31:0] avs_writedata, // write data
    output logic [3:0] avs_byteenable, // byte lanes
    input wire logic [31:0] avs_readdata, // read data
    input wire logic avs_waitrequest // slave stall
);
    // idle bus at time zero
    initial begin
        avs_address = 12'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
    end
    // one word; request held until waitrequest is sampled low
    task automatic xfer(input logic wr, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clock);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= d;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : xfer
    // busy must read clear, parameter goes in before the code
    task automatic command(input logic [7:0] code, input logic [31:0] prm);
        logic [31:0] st;
        st = 32'h1;
        while (st[0] !== 1'b0) xfer(1'b0, `HAP_ADDR_STATUS, 32'h0, st);
        xfer(1'b1, `HAP_ADDR_PARAM, prm, st);
        xfer(1'b1, `HAP_ADDR_CMD, {24'h0, code}, st);
    endtask : command
endmodule : hap_host_model

// ---- dv/host_adapter_delivery_pipes_tb.sv ----
// self-checking bench for the delivery pipes block
`timescale 1ns/1ps
`include "hap_cfg.svh"
module host_adapter_delivery_pipes_tb;
    import hap_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [11:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic init_start = 1'b0, enq_valid = 1'b0, deq_req = 1'b0;
    logic cmd_taken = 1'b0, cmd_complete = 1'b0, timer_exempt = 1'b0;
    logic [2:0] cmd_status = 3'h0;
    hap_enq_t enq_data = '0;
    logic init_busy, enq_done, enq_refused, result_wr, deq_done, deq_empty;
    logic adapter_irq, host_irq, halted, rf, em;
    hap_result_t result_data;
    hap_elem_t deq_elem;
    hap_cmd_t cmd_out;
    logic [7:0] request_credit;
    int error_cnt = 0, compares = 0, cyc = 0;
    logic [32:0] rw;
    hap_elem_t el;
    // ====
    // clock, and a ceiling on run length against hangs
    always #50 clock = ~clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            test_done();
        end
    end
    // short timer so the timeout shows within a few cycles
    hap_pipes #(.TMO_CYCLES(32'd50)) u_hap_pipes (.clock(clock),
        .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .init_start(init_start),
        .init_busy(init_busy), .enq_valid(enq_valid), .enq_data(enq_data),
        .enq_done(enq_done), .enq_refused(enq_refused),
        .result_wr(result_wr), .result_data(result_data),
        .deq_req(deq_req), .deq_done(deq_done), .deq_empty(deq_empty),
        .deq_elem(deq_elem), .timer_exempt(timer_exempt),
        .adapter_irq(adapter_irq), .cmd_out(cmd_out),
        .cmd_taken(cmd_taken), .cmd_complete(cmd_complete),
        .cmd_status(cmd_status), .err_valid(1'b0), .err_code(32'h0),
        .host_irq(host_irq), .request_credit(request_credit),
        .halted(halted));
    hap_host_model u_host (.clock(clock), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    // ====
    // shared helpers
    task automatic chk(input string nm, input logic [32:0] e,
                       input logic [32:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rd(input logic [11:0] a, input logic [31:0] e,
                      input string nm);
        logic [31:0] q;
        u_host.xfer(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask : rd
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        u_host.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic pulse(input logic cpl);
        @(posedge clock);
        cmd_complete <= cpl;
        cmd_taken <= !cpl;
        @(posedge clock);
        cmd_complete <= 1'b0;
        cmd_taken <= 1'b0;
        repeat (2) @(posedge clock);
    endtask : pulse
    // enqueue held to done; notes any result store on the way
    task automatic enq(input logic [27:0] t, input logic rp, input logic ns,
                       input logic [31:0] r);
        rw = 33'h0;
        @(posedge clock);
        enq_valid <= 1'b1;
        enq_data <= {t, rp, ns, r};
        do begin
            @(posedge clock);
            if (result_wr === 1'b1) rw = {1'b1, result_data};
        end while (enq_done !== 1'b1);
        rf = enq_refused;
        enq_valid <= 1'b0;
        repeat (2) @(posedge clock);
    endtask : enq
    task automatic deq();
        @(posedge clock);
        deq_req <= 1'b1;
        do @(posedge clock); while (deq_done !== 1'b1);
        em = deq_empty;
        el = deq_elem;
        deq_req <= 1'b0;
        repeat (2) @(posedge clock);
    endtask : deq
    // ====
    // scenarios
    task automatic t_init();
        chk("credit at reset", 32'(`HAP_CREDIT_MAX), 32'(request_credit));
        @(posedge clock);
        init_start <= 1'b1;
        do @(posedge clock); while (init_busy !== 1'b1);
        init_start <= 1'b0;
        do @(posedge clock); while (init_busy === 1'b1);
        rd(`HAP_ADDR_HPIPE, `HAP_DUMMY_ELEM, "first dummy");
        rd(`HAP_ADDR_HPIPE + 12'h3fc, `HAP_DUMMY_ELEM, "last slot");
        deq();
        chk("empty after init", 32'h1, 32'(em));
    endtask : t_init
    task automatic t_pipes();
        wr(`HAP_ADDR_HPIPE, 32'h1234_5670);
        @(posedge clock);
        chk("adapter irq", 32'h1, 32'(adapter_irq));
        deq();
        chk("request taken", 32'h1234_5670, el);
        deq();
        chk("pipe empty again", 32'h1, 32'(em));
        enq(28'habcdef0, 1'b1, 1'b1, 32'h0012_0034);
        chk("failing result", 33'h1_0012_0034, rw);
        rd(`HAP_ADDR_APIPE, 32'habcd_ef0a, "reply element");
        chk("host irq", 32'h1, 32'(host_irq));
        enq(28'h0000123, 1'b0, 1'b0, 32'h0);
        chk("request result", 33'h1_0000_0000, rw);
        rd(`HAP_ADDR_APIPE + 12'h004, 32'h0000_1230, "req element");
        chk("credit spent", 32'h36, 32'(request_credit));
        wr(`HAP_ADDR_HPIPE + 12'h004, 32'h0000_4562);
        deq();
        chk("host reply", 32'h0000_4562, el);
        chk("credit back", 32'h37, 32'(request_credit));
    endtask : t_pipes
    task automatic t_cmd();
        wr(`HAP_ADDR_CONTROL, 32'h1);
        rd(`HAP_ADDR_STATUS, 32'h0000_0002, "irq pending");
        @(posedge clock);
        chk("irq cleared", 32'h0, 32'(host_irq));
        u_host.command(8'h30, 32'h0000_1000);
        chk("cmd param", 32'h0000_1000, cmd_out.param);
        rd(`HAP_ADDR_STATUS, 32'h1, "busy set");
        pulse(1'b0);
        rd(`HAP_ADDR_STATUS, 32'h0, "busy clear");
        cmd_status <= 3'h7;
        pulse(1'b1);
        chk("completion irq", 32'h1, 32'(host_irq));
        rd(`HAP_ADDR_STATUS, 32'h0000_0702, "status");
        @(posedge clock);
        chk("read clears irq", 32'h0, 32'(host_irq));
        u_host.command(`HAP_CMD_DOWNLOAD, 32'h0000_2000);
        pulse(1'b0);
        u_host.command(8'h30, 32'h0000_3000);
        chk("locked after load", 32'h31, 32'(cmd_out.code));
    endtask : t_cmd
    task automatic t_credit();
        for (int i = 0; i < `HAP_CREDIT_MAX; i++) begin
            enq(28'(i), 1'b0, 1'b0, 32'h0);
            chk("request accepted", 32'h0, 32'(rf));
        end
        enq(28'h0000999, 1'b0, 1'b0, 32'h0);
        chk("no credit refused", 32'h1, 32'(rf));
        chk("credit empty", 32'h0, 32'(request_credit));
    endtask : t_credit
    task automatic t_timeout();
        rd(`HAP_ADDR_STATUS, 32'h0000_0702, "irq before timeout");
        wr(`HAP_ADDR_HPIPE + 12'h008, 32'h0000_7770);
        deq();
        timer_exempt <= 1'b1;
        repeat (60) @(posedge clock);
        chk("exempt no halt", 32'h0, 32'(halted));
        timer_exempt <= 1'b0;
        repeat (60) @(posedge clock);
        chk("halted", 32'h1, 32'(halted));
        chk("timeout irq", 32'h1, 32'(host_irq));
        rd(`HAP_ADDR_ERROR, `HAP_ERR_TIMEOUT, "error code");
        enq(28'h0000777, 1'b1, 1'b0, 32'h0);
        chk("halted refuses", 32'h1, 32'(rf));
    endtask : t_timeout
    task automatic test_done();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done
    // ====
    // main sequence
    initial begin
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        repeat (2) @(posedge clock);
        t_init();
        t_pipes();
        t_cmd();
        t_credit();
        t_timeout();
        test_done();
    end
endmodule : host_adapter_delivery_pipes_tb
